// ---- rtl/ftf_defines.svh ----
// Offsets, field positions, reset values and timing counts for the filter
`ifndef FTF_DEFINES_SVH
`define FTF_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define FTF_ADDR_FAN1_CEIL 8'h38
`define FTF_ADDR_FAN2_CEIL 8'h39
`define FTF_ADDR_FAN3_CEIL 8'h3a
`define FTF_ADDR_BELOW_Z1 8'h62
`define FTF_ADDR_Z2_Z3 8'h63
`define FTF_ADDR_FAN1_FLOOR 8'h64
`define FTF_ADDR_FAN2_FLOOR 8'h65
`define FTF_ADDR_FAN3_FLOOR 8'h66

// ----------------------------------------------------------------------
// Reset values and field positions
// ----------------------------------------------------------------------
`define FTF_RST_CEIL 8'hff
`define FTF_RST_FLOOR 8'h80
`define FTF_RST_SMOOTH 8'h00
`define FTF_BELOW_LSB 5
`define FTF_Z1_EN_BIT 3
`define FTF_Z2_EN_BIT 7
`define FTF_Z3_EN_BIT 3
`define FTF_DUTY_FULL 8'hff
`define FTF_DUTY_OFF 8'h00

// ----------------------------------------------------------------------
// Timing: clock in MHz and conversion period per zone, in microseconds
// ----------------------------------------------------------------------
`define FTF_CLK_MHZ 25
`define FTF_CONV_US 100000

`endif

// ---- rtl/ftf_pkg.sv ----
// Types shared by the fan temperature filter
package ftf_pkg;

  // Per-zone limits supplied by the surrounding fan logic
  typedef struct packed {
    logic [7:0] fan_limit;
    logic [7:0] abs_limit;
    logic [3:0] hyst;
  } ftf_zone_lim_t;

  // Register bus request
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ftf_reg_req_t;

  typedef enum logic [1:0] {
    FTF_IDLE,
    FTF_ON,
    FTF_HOLD_FLOOR,
    FTF_FULL
  } ftf_fan_state_t;

endpackage : ftf_pkg

// ---- rtl/ftf_zone_filter.sv ----
// One zone: no-spike median of four and exponential smoother
`timescale 1ns/10ps
`include "ftf_defines.svh"
module ftf_zone_filter
  import ftf_pkg::*;
#(
  parameter int W = 8
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic sample_valid,
  input wire logic [W-1:0] temp_in,
  input wire logic smooth_en,
  input wire logic [2:0] time_sel,
  output logic [W-1:0] despiked,
  output logic [W-1:0] smoothed
);

  // ----------------------------------------------------------------------
  // Sample history
  // ----------------------------------------------------------------------
  logic [W-1:0] hist [3];
  logic primed;
  // Signed compare helpers
  function automatic logic [W-1:0] smin(input logic [W-1:0] a,
                                        input logic [W-1:0] b);
    smin = ($signed(a) < $signed(b)) ? a : b;
  endfunction : smin
  function automatic logic [W-1:0] smax(input logic [W-1:0] a,
                                        input logic [W-1:0] b);
    smax = ($signed(a) > $signed(b)) ? a : b;
  endfunction : smax

  // Middle two of four: max of the pair-mins and min of the pair-maxes
  wire [W-1:0] lo_a = smin(temp_in, hist[0]);
  wire [W-1:0] hi_a = smax(temp_in, hist[0]);
  wire [W-1:0] lo_b = smin(hist[1], hist[2]);
  wire [W-1:0] hi_b = smax(hist[1], hist[2]);
  wire [W-1:0] mid_lo = smax(lo_a, lo_b);
  wire [W-1:0] mid_hi = smin(hi_a, hi_b);
  wire signed [W:0] mid_sum = $signed({mid_lo[W-1], mid_lo}) +
                              $signed({mid_hi[W-1], mid_hi});
  wire [W-1:0] next_despiked = mid_sum[W:1]; // R3

  // ----------------------------------------------------------------------
  // Smoother coefficients: GAIN over 2^N, longer time for lower code except code 100 (3/16), faster than 101 (1/8)
  // ----------------------------------------------------------------------
  // Fractional bits kept so tiny steps are not lost to truncation
  localparam int F = 8;
  logic [3:0] shift_n;
  logic [2:0] gain;
  always_comb
  begin
    shift_n = 4'd6;
    gain = 3'd1;
    case (time_sel) // R6 R7
      3'b000: begin shift_n = 4'd6; gain = 3'd1; end
      3'b001: begin shift_n = 4'd5; gain = 3'd1; end
      3'b010: begin shift_n = 4'd6; gain = 3'd3; end
      3'b011: begin shift_n = 4'd4; gain = 3'd1; end
      3'b100: begin shift_n = 4'd4; gain = 3'd3; end
      3'b101: begin shift_n = 4'd3; gain = 3'd1; end
      3'b110: begin shift_n = 4'd2; gain = 3'd1; end
      default: begin shift_n = 4'd1; gain = 3'd1; end
    endcase
  end

  logic signed [W+F-1:0] acc;
  wire signed [W+F-1:0] target = $signed({next_despiked, {F{1'b0}}});
  wire signed [W+F+3:0] diff_g = (target - acc) * $signed({1'b0, gain});
  wire signed [W+F+3:0] step = diff_g >>> shift_n;
  wire signed [W+F-1:0] next_acc = smooth_en
    ? (W+F)'(acc + step[W+F-1:0]) // R5
    : target; // R18

  // Update once per conversion; filter runs whatever enable says
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      hist[0] <= '0;
      hist[1] <= '0;
      hist[2] <= '0;
      primed <= 1'b0;
      despiked <= '0;
      acc <= '0;
    end
    else if (sample_valid) // R4 R18
    begin
      hist[0] <= primed ? temp_in : temp_in;
      hist[1] <= primed ? hist[0] : temp_in;
      hist[2] <= primed ? hist[1] : temp_in;
      primed <= 1'b1;
      despiked <= primed ? next_despiked : temp_in;
      acc <= primed ? next_acc : $signed({temp_in, {F{1'b0}}});
    end
  end

  assign smoothed = acc[W+F-1:F];

endmodule : ftf_zone_filter

// ---- rtl/ftf_top.sv ----
// Fan temperature filter, below-limit choice and duty floor/ceiling
//
// Operation
// R1: Below-limit select bits at 62h bits 7:5
// R2: Below limit: off, or floor when set
// R3: De-spike: drop max/min of four, average
// R4: De-spike always runs and drives control
// R5: Smooth adds GAIN times difference over 2^N
// R6: N and GAIN chosen from time field
// R7: Eight codes, 35 s down to 0.8 s
// R8: Enables at 62h.3, 63h.7, 63h.3
// R9: Temperature readback stays unfiltered
// R10: Lock blocks writes to 62h, 63h
// R11: Floor register sets least duty, reset 80h
// R12: Lock blocks writes to floor registers
// R13: Duty clamped to ceiling, reset FFh
// R14: Above absolute limit force full duty
// R15: Release full duty after hysteresis drop
// R16: At limit turn on, above ramp up
// R17: Hold floor until limit minus hysteresis
// R18: Update per conversion; disabled smoothing passes
`timescale 1ns/10ps
`include "ftf_defines.svh"
module ftf_top
  import ftf_pkg::*;
#(
  parameter int NZ = 3
)
(
  input wire logic clk,
  input wire logic rst,
  input wire ftf_reg_req_t reg_req,
  input wire logic reg_sel,
  output logic [7:0] reg_rdata,
  input wire logic lock,
  input wire logic [NZ-1:0] sample_valid,
  input wire logic [NZ*8-1:0] temp_raw,
  input wire ftf_zone_lim_t [NZ-1:0] zone_lim,
  input wire logic [NZ*2-1:0] fan_zone_sel,
  input wire logic [NZ*8-1:0] ramp_duty,
  output logic [NZ*8-1:0] temp_readback,
  output logic [NZ*8-1:0] zone_temp_ctl,
  output logic [NZ*8-1:0] fan_duty
);

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [7:0] ceil_reg [NZ];
  logic [7:0] floor_reg [NZ];
  logic [7:0] below_z1;
  logic [7:0] z2_z3;

  // Address decode
  wire wr_en = reg_sel && reg_req.wr;
  wire hit_bz1 = (reg_req.addr == `FTF_ADDR_BELOW_Z1);
  wire hit_z23 = (reg_req.addr == `FTF_ADDR_Z2_Z3);
  wire [1:0] ceil_idx = 2'(reg_req.addr - `FTF_ADDR_FAN1_CEIL);
  wire [1:0] floor_idx = 2'(reg_req.addr - `FTF_ADDR_FAN1_FLOOR);
  wire hit_ceil = (reg_req.addr >= `FTF_ADDR_FAN1_CEIL) &&
                  (reg_req.addr <= `FTF_ADDR_FAN3_CEIL);
  wire hit_floor = (reg_req.addr >= `FTF_ADDR_FAN1_FLOOR) &&
                   (reg_req.addr <= `FTF_ADDR_FAN3_FLOOR);

  // Smoothing config; lock makes it read-only
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      below_z1 <= `FTF_RST_SMOOTH;
      z2_z3 <= `FTF_RST_SMOOTH;
    end
    else if (wr_en && !lock) // R10
    begin
      if (hit_bz1)
        below_z1 <= {reg_req.wdata[7:5], 1'b0, reg_req.wdata[3:0]}; // R1
      else if (hit_z23)
        z2_z3 <= reg_req.wdata; // R8
    end
  end

  // Ceiling and floor registers; ceiling is not lockable
  genvar g;
  generate
    for (g = 0; g < NZ; g++)
    begin : g_reg
      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          ceil_reg[g] <= `FTF_RST_CEIL; // R13
          floor_reg[g] <= `FTF_RST_FLOOR; // R11
        end
        else if (wr_en)
        begin
          if (hit_ceil && ceil_idx == 2'(g))
            ceil_reg[g] <= reg_req.wdata;
          else if (hit_floor && floor_idx == 2'(g) && !lock) // R12
            floor_reg[g] <= reg_req.wdata;
        end
      end
    end
  endgenerate

  // Read mux; unmapped offsets read zero
  wire [7:0] rd_mux = hit_bz1 ? below_z1 :
                      hit_z23 ? z2_z3 :
                      hit_ceil ? ceil_reg[ceil_idx] :
                      hit_floor ? floor_reg[floor_idx] : 8'h00;
  always_ff @(posedge clk)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (reg_sel && !reg_req.wr)
      reg_rdata <= rd_mux;
  end

  // ----------------------------------------------------------------------
  // Per-zone filters
  // ----------------------------------------------------------------------
  wire [NZ-1:0] zen = {z2_z3[`FTF_Z3_EN_BIT], z2_z3[`FTF_Z2_EN_BIT],
                       below_z1[`FTF_Z1_EN_BIT]}; // R8
  wire [NZ*3-1:0] ztime = {z2_z3[2:0], z2_z3[6:4], below_z1[2:0]};
  wire [NZ-1:0] hold_floor = below_z1[`FTF_BELOW_LSB+NZ-1:`FTF_BELOW_LSB];

  logic [7:0] ctl_t [NZ];
  generate
    for (g = 0; g < NZ; g++)
    begin : g_zone
      ftf_zone_filter #(.W(8)) u_filt (
        .clk(clk),
        .rst(rst),
        .sample_valid(sample_valid[g]),
        .temp_in(temp_raw[g*8+:8]),
        .smooth_en(zen[g]),
        .time_sel(ztime[g*3+:3]),
        .despiked(),
        .smoothed(ctl_t[g])
      );
      assign zone_temp_ctl[g*8+:8] = ctl_t[g];
    end
  endgenerate

  // Readback stays raw, smoothing never reaches it
  always_ff @(posedge clk)
  begin
    if (rst)
      temp_readback <= '0;
    else
      temp_readback <= temp_raw; // R9
  end

  // ----------------------------------------------------------------------
  // Per-fan duty state machine
  // ----------------------------------------------------------------------
  ftf_fan_state_t st [NZ];
  ftf_fan_state_t next_st [NZ];
  generate
    for (g = 0; g < NZ; g++)
    begin : g_fan
      wire [1:0] zi = fan_zone_sel[g*2+:2];
      wire [1:0] zs = (zi < 2'(NZ)) ? zi : 2'd0;
      wire signed [8:0] t = $signed({ctl_t[zs][7], ctl_t[zs]});
      wire signed [8:0] lim = $signed({zone_lim[zs].fan_limit[7],
                                        zone_lim[zs].fan_limit});
      wire signed [8:0] abl = $signed({zone_lim[zs].abs_limit[7],
                                        zone_lim[zs].abs_limit});
      wire signed [8:0] hy = $signed({5'b0, zone_lim[zs].hyst});
      // Absolute limit of -128 disables the override
      wire abs_dis = (zone_lim[zs].abs_limit == 8'h80);
      wire over_abs = !abs_dis && (t > abl); // R14
      wire abs_rel = (t <= abl - hy); // R15
      wire at_lim = (t >= lim); // R16
      wire off_rel = (t < lim - hy); // R17
      wire [7:0] rd = ramp_duty[g*8+:8];
      wire [7:0] up = (rd < floor_reg[g]) ? floor_reg[g] : rd; // R11
      wire [7:0] clamped = (up > ceil_reg[g]) ? ceil_reg[g] : up; // R13
      wire [7:0] below = hold_floor[g] ? floor_reg[g] : `FTF_DUTY_OFF;

      always_comb
      begin
        next_st[g] = st[g];
        case (st[g])
          FTF_IDLE:
            if (over_abs)
              next_st[g] = FTF_FULL;
            else if (at_lim)
              next_st[g] = FTF_ON;
          FTF_ON:
            if (over_abs)
              next_st[g] = FTF_FULL;
            else if (!at_lim)
              next_st[g] = FTF_HOLD_FLOOR;
          FTF_HOLD_FLOOR:
            if (over_abs)
              next_st[g] = FTF_FULL;
            else if (at_lim)
              next_st[g] = FTF_ON;
            else if (off_rel)
              next_st[g] = FTF_IDLE; // R17
          default:
            if (abs_rel)
              next_st[g] = at_lim ? FTF_ON : FTF_HOLD_FLOOR; // R15
        endcase
      end

      wire [7:0] next_duty =
        (next_st[g] == FTF_FULL) ? `FTF_DUTY_FULL : // R14
        (next_st[g] == FTF_ON) ? clamped :
        (next_st[g] == FTF_HOLD_FLOOR) ? floor_reg[g] : below; // R2

      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          st[g] <= FTF_IDLE;
          fan_duty[g*8+:8] <= `FTF_DUTY_OFF;
        end
        else
        begin
          st[g] <= next_st[g];
          fan_duty[g*8+:8] <= next_duty;
        end
      end
    end
  endgenerate

endmodule : ftf_top

// ---- bench/ftf_top_chk.sv ----
// Port checker for the fan temperature filter
`timescale 1ns/10ps
module ftf_top_chk
  import ftf_pkg::*;
#(
  parameter int NZ = 3
)
(
  input wire logic clk,
  input wire logic rst,
  input wire ftf_reg_req_t reg_req,
  input wire logic reg_sel,
  input wire logic [7:0] reg_rdata,
  input wire logic lock,
  input wire logic [NZ-1:0] sample_valid,
  input wire logic [NZ*8-1:0] temp_raw,
  input wire ftf_zone_lim_t [NZ-1:0] zone_lim,
  input wire logic [NZ*2-1:0] fan_zone_sel,
  input wire logic [NZ*8-1:0] ramp_duty,
  input wire logic [NZ*8-1:0] temp_readback,
  input wire logic [NZ*8-1:0] zone_temp_ctl,
  input wire logic [NZ*8-1:0] fan_duty
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ------
  // Shadows
  // ------
  // Writes land only while unlocked; bit 4 of 62h is reserved
  logic [7:0] cfg;
  logic [7:0] flr;
  wire wr_ok = reg_sel && reg_req.wr && !lock;
  wire rd = reg_sel && !reg_req.wr;
  always_ff @(posedge clk)
    if (rst) cfg <= 8'h00;
    else if (wr_ok && reg_req.addr == 8'h62) cfg <= reg_req.wdata & 8'hef;
  always_ff @(posedge clk)
    if (rst) flr <= 8'h80;
    else if (wr_ok && reg_req.addr == 8'h64) flr <= reg_req.wdata;
  // Zone 0 as seen by fan 1, widened so limit minus hysteresis cannot wrap
  wire signed [8:0] t0 = {zone_temp_ctl[7], zone_temp_ctl[7:0]};
  wire signed [8:0] lm = {zone_lim[0].fan_limit[7], zone_lim[0].fan_limit};
  wire signed [8:0] ab = {zone_lim[0].abs_limit[7], zone_lim[0].abs_limit};
  wire signed [8:0] hy = {5'h00, zone_lim[0].hyst};
  wire sel0 = fan_zone_sel[1:0] == 2'h0;
  wire cold = sel0 && t0 < lm - hy && t0 < ab - hy;
  wire hot = sel0 && t0 > ab && zone_lim[0].abs_limit != 8'h80;
  wire [7:0] r0 = temp_raw[7:0];
  sequence same4;
    (sample_valid[0] && !cfg[3] && $stable(r0))[*4];
  endsequence
  // ------
  // Properties
  // ------
  chk_readback_raw:
    assert property (!$past(rst) |-> temp_readback == $past(temp_raw))
      else $error("readback is not the raw copy");
  chk_ctl_holds:
    assert property (!sample_valid[0] |=> $stable(zone_temp_ctl[7:0]))
      else $error("control temperature moved without a sample");
  chk_steady_pass:
    assert property (same4 |=> zone_temp_ctl[7:0] == $past(r0))
      else $error("steady input not passed through");
  chk_hot_full:
    assert property (hot [*2] |=> fan_duty[7:0] == 8'hff)
      else $error("no full duty above absolute limit");
  chk_cold_off:
    assert property ((cold && !cfg[5]) [*2] |=> fan_duty[7:0] == 8'h00)
      else $error("duty not off below limit");
  chk_cold_floor:
    assert property ((cold && cfg[5]) [*2] |=> fan_duty[7:0] == $past(flr))
      else $error("duty not at floor below limit");
  chk_cfg_read:
    assert property (rd && reg_req.addr == 8'h62 |=> reg_rdata == cfg)
      else $error("configuration readback wrong");
  chk_floor_read:
    assert property (rd && reg_req.addr == 8'h64 |=> reg_rdata == flr)
      else $error("floor readback wrong");
endmodule : ftf_top_chk

// ---- bench/tb_top.sv ----
// Self-checking testbench for the fan temperature filter
`timescale 1ns/10ps
module tb_top;
  import ftf_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  ftf_reg_req_t req = '0;
  logic sel = 1'b0;
  logic lock = 1'b0;
  logic [2:0] sv = 3'h0;
  logic [23:0] raw = 24'h000000;
  logic [23:0] ramp = 24'h202020;
  ftf_zone_lim_t [2:0] lim;
  logic [7:0] rdata;
  logic [23:0] rb;
  logic [23:0] ctl;
  logic [23:0] duty;
  logic [7:0] rd;
  logic [7:0] prev;
  int errors = 0;
  int checked = 0;
  int cycles = 0;
  // Rows: address, write data, reset value, readback after write
  localparam logic [31:0] rows [11] = '{32'h38a5ffa5, 32'h395aff5a,
    32'h3a3cff3c, 32'h62ff00ef, 32'h63c300c3, 32'h64118011, 32'h65228022,
    32'h66338033, 32'h3b770000, 32'h61770000, 32'h67770000};
  // Rows: zone temperature, fan 1 duty
  localparam logic [15:0] heat [5] = '{16'h51ff, 16'h4eff, 16'h4c90,
    16'h2e40, 16'h2b00};
  // Fan limit 30h, absolute limit 50h, hysteresis 4 on every zone
  assign lim = {3{20'h30504}};
  ftf_top #(.NZ(3)) ftf_top_inst (.clk(clk), .rst(rst), .reg_req(req),
    .reg_sel(sel), .reg_rdata(rdata), .lock(lock), .sample_valid(sv),
    .temp_raw(raw), .zone_lim(lim), .fan_zone_sel(6'h24),
    .ramp_duty(ramp), .temp_readback(rb), .zone_temp_ctl(ctl),
    .fan_duty(duty));
  always #20 clk = ~clk;
  // Cut a hang short well past the expected run length
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      errors = errors + 1;
      stop_test();
    end
  end
  // ------
  // Tasks
  // ------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked = checked + 1;
    if (seen !== exp)
    begin
      errors = errors + 1;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 sel = 1'b1;
    req = '{w, a, d};
    @(posedge clk);
    #1 sel = 1'b0;
    rd = rdata;
  endtask : acc
  // Back-to-back samples on all zones, then one edge for the duty stage
  task automatic put(input logic [7:0] t, input int n);
    @(posedge clk);
    #1 sv = 3'h7;
    raw = {3{t}};
    repeat (n) @(posedge clk);
    #1 sv = 3'h0;
    @(posedge clk);
    #1;
  endtask : put
  task automatic do_rst();
    @(posedge clk);
    #1 rst = 1'b1;
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
  endtask : do_rst
  task automatic stop_test();
    if (errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test
  // ------
  // Sequence
  // ------
  initial
  begin
    do_rst();
    foreach (rows[i])
    begin
      acc(1'b0, rows[i][31:24], 8'h00);
      check(rd, rows[i][15:8]);
      acc(1'b1, rows[i][31:24], rows[i][23:16]);
      acc(1'b0, rows[i][31:24], 8'h00);
      check(rd, rows[i][7:0]);
    end
    // Locked writes of zero: only the ceilings may change
    lock = 1'b1;
    foreach (rows[i])
    begin
      acc(1'b1, rows[i][31:24], 8'h00);
      acc(1'b0, rows[i][31:24], 8'h00);
      check(rd, rows[i][30] ? rows[i][7:0] : 8'h00);
    end
    lock = 1'b0;
    // A lone spike is dropped, a repeated one is averaged in
    do_rst();
    put(8'h20, 5);
    for (int k = 0; k < 3; k++)
    begin
      put(8'h60, 1);
      check(ctl[7:0], 8'(32 * k + 32));
      check(rb[7:0], 8'h60);
    end
    // Every time code: zones 1 and 2 smoothed, zone 3 de-spiked only
    for (int c = 0; c < 8; c++)
    begin
      do_rst();
      acc(1'b1, 8'h62, {5'h01, c[2:0]});
      acc(1'b1, 8'h63, {1'b1, c[2:0], 1'b0, c[2:0]});
      put(8'h00, 1);
      put(8'h40, 6);
      check({7'h00, ctl[7:0] < 8'h40 && ctl[7:0] != 8'h00}, 8'h01);
      check({7'h00, ctl[15:8] < 8'h40}, 8'h01);
      check(ctl[23:16], 8'h40);
      if (c == 0)
        prev = ctl[7:0];
    end
    check({7'h00, ctl[7:0] > prev}, 8'h01);
    // Below limit: off, then floor; at limit the floor beats a low ramp
    do_rst();
    put(8'h10, 5);
    check(duty[7:0], 8'h00);
    acc(1'b1, 8'h62, 8'ha0);
    put(8'h10, 1);
    check(duty[7:0], 8'h80);
    check(duty[15:8], 8'h00);
    check(duty[23:16], 8'h80);
    acc(1'b1, 8'h62, 8'h00);
    acc(1'b1, 8'h64, 8'h40);
    acc(1'b1, 8'h38, 8'h90);
    put(8'h30, 5);
    check(duty[7:0], 8'h40);
    ramp = 24'ha0a0a0;
    put(8'h30, 1);
    check(duty[7:0], 8'h90);
    foreach (heat[i])
    begin
      put(heat[i][15:8], 5);
      check(duty[7:0], heat[i][7:0]);
    end
    stop_test();
  end
endmodule : tb_top
bind ftf_top ftf_top_chk #(.NZ(NZ)) ftf_top_chk_inst (.clk(clk), .rst(rst),
  .reg_req(reg_req), .reg_sel(reg_sel), .reg_rdata(reg_rdata),
  .lock(lock), .sample_valid(sample_valid), .temp_raw(temp_raw),
  .zone_lim(zone_lim), .fan_zone_sel(fan_zone_sel), .ramp_duty(ramp_duty),
  .temp_readback(temp_readback), .zone_temp_ctl(zone_temp_ctl),
  .fan_duty(fan_duty));
